/* src/pse_fault_remap_defs.svh */
// Constants for the turn-on fault cause and port remap register block
`ifndef PSE_FAULT_REMAP_DEFS_SVH
`define PSE_FAULT_REMAP_DEFS_SVH
`define CMD_FAULT_READ      8'h24
`define CMD_FAULT_CLEAR     8'h25
`define CMD_PORT_REMAP      8'h26
`define REMAP_RESET         8'hE4
`define FAULT_RESET         8'h00
`define CAUSE_NONE          2'h0
`define CAUSE_DETECT        2'h1
`define CAUSE_CLASS         2'h2
`define CAUSE_POWER         2'h3
`define REG_ZERO            8'h00
`define CAUSE_W             2
`define REMAP_FIELDS        4
`endif

/* src/pse_fault_remap_pkg.sv */
// Types shared by the fault cause and port remap block
package pse_fault_remap_pkg;
	typedef enum logic [2:0] {
		ST_IDLE  = 3'b001,
		ST_WRITE = 3'b010,
		ST_READ  = 3'b100
	} cmd_state_t;
endpackage

/* src/pse_fault_remap.sv */
// Turn-on fault cause and logical-to-physical remap registers of one four-channel group
// Contract
// - Failed turn-on latches two-bit cause code
// - Channel switched off clears its cause
// - Codes: none, detect, class, insufficient power
// - Report cause only if enable-change flag clear
// - Allocation refusal reports insufficient power code
// - Dual-signature pair channels update separately
// - Single-signature pair channels update together
// - Remap write ignored unless group all off
// - Two-bit field selects physical channel
// - Power-on remap value is identity mapping
// - Remap contents survive reset pin assertion
// - Duplicate physical codes discard remap write
`include "pse_fault_remap_defs.svh"
module pse_fault_remap #(
	parameter int N_CH = 4
) (
	input  wire logic             i_clk,
	input  wire logic             i_reset,
	input  wire logic             i_por,
	input  wire logic             i_cmd_valid,
	input  wire logic             i_cmd_write,
	input  wire logic [7:0]       i_cmd_code,
	input  wire logic [7:0]       i_cmd_data,
	input  wire logic [N_CH-1:0]  i_ch_off,
	input  wire logic [N_CH-1:0]  i_turn_off,
	input  wire logic [N_CH-1:0]  i_start_fail,
	input  wire logic [N_CH-1:0]  i_detect_bad,
	input  wire logic [N_CH-1:0]  i_class_bad,
	input  wire logic [N_CH-1:0]  i_power_denied,
	input  wire logic [N_CH-1:0]  i_power_enable_change_flag,
	input  wire logic [1:0]       i_four_pair,
	input  wire logic [1:0]       i_single_signature,
	output logic      [7:0]       o_rd_data,
	output logic                  o_rd_valid,
	output logic      [7:0]       o_port_remap_control,
	output logic      [7:0]       o_turn_on_fault_cause
);

	pse_fault_remap_pkg::cmd_state_t state;
	pse_fault_remap_pkg::cmd_state_t next_state;
	logic [7:0] port_remap_control;
	logic [7:0] next_port_remap_control;
	logic [7:0] turn_on_fault_cause;
	logic [7:0] next_turn_on_fault_cause;
	logic [7:0] rd_data;
	logic [7:0] next_rd_data;
	logic       rd_valid;
	logic       next_rd_valid;
	logic [7:0] cmd_code;
	logic [7:0] next_cmd_code;
	logic [7:0] cmd_data;
	logic [7:0] next_cmd_data;

	// Cause code for one channel; allocation refusal outranks the others
	function automatic logic [1:0] cause_of(input logic det, input logic cls, input logic pwr);
		logic [1:0] c;
		c = `CAUSE_NONE;
		if (pwr) begin
			c = `CAUSE_POWER;
		end else if (cls) begin
			c = `CAUSE_CLASS;
		end else if (det) begin
			c = `CAUSE_DETECT;
		end
		return c;
	endfunction

	// One two-bit field of a packed register, lowest field at index zero
	function automatic logic [1:0] field_of(input logic [7:0] v, input int idx);
		return v[`CAUSE_W*idx +: `CAUSE_W];
	endfunction

	// True when no two fields share a physical code; a duplicate would leave a channel unreachable
	function automatic logic remap_unique(input logic [7:0] v);
		logic ok;
		ok = 1'b1;
		for (int a = 0; a < `REMAP_FIELDS; a++) begin
			for (int b = a + 1; b < `REMAP_FIELDS; b++) begin
				if (field_of(v, a) == field_of(v, b)) begin
					ok = 1'b0;
				end
			end
		end
		return ok;
	endfunction

	// True when every channel of the group is off; remapping a live channel would move its power
	function automatic logic group_all_off(input logic [N_CH-1:0] off);
		return &off;
	endfunction

	// Command decode: a request is taken, then acted on the next cycle
	always_comb begin
		next_state    = pse_fault_remap_pkg::ST_IDLE;
		next_cmd_code = cmd_code;
		next_cmd_data = cmd_data;
		case (state)
			pse_fault_remap_pkg::ST_IDLE,
			pse_fault_remap_pkg::ST_WRITE,
			pse_fault_remap_pkg::ST_READ: begin
				if (i_cmd_valid) begin
					next_cmd_code = i_cmd_code;
					next_cmd_data = i_cmd_data;
					next_state    = i_cmd_write ? pse_fault_remap_pkg::ST_WRITE : pse_fault_remap_pkg::ST_READ;
				end
			end
			default: begin
				next_state = pse_fault_remap_pkg::ST_IDLE;
			end
		endcase
	end

	// Read answers; the clear-on-read view empties the cause register
	always_comb begin
		next_rd_data  = rd_data;
		next_rd_valid = 1'b0;
		if (state == pse_fault_remap_pkg::ST_READ) begin
			next_rd_valid = 1'b1;
			case (cmd_code)
				`CMD_FAULT_READ,
				`CMD_FAULT_CLEAR: next_rd_data = turn_on_fault_cause;
				`CMD_PORT_REMAP:  next_rd_data = port_remap_control;
				default:          next_rd_data = `REG_ZERO;
			endcase
		end
	end

	// Fault cause update; a new fault wins over clear-on-read in the same cycle
	always_comb begin
		logic [N_CH-1:0] hit;
		logic [1:0]      code [N_CH];
		logic            clear_hit;
		hit       = '0;
		clear_hit = state == pse_fault_remap_pkg::ST_READ && cmd_code == `CMD_FAULT_CLEAR;
		for (int k = 0; k < N_CH; k++) begin
			code[k] = `CAUSE_NONE;
		end
		next_turn_on_fault_cause = turn_on_fault_cause;
		if (clear_hit) begin
			next_turn_on_fault_cause = `FAULT_RESET;
		end
		for (int k = 0; k < N_CH; k++) begin
			hit[k]  = i_start_fail[k] && !i_power_enable_change_flag[k];
			code[k] = cause_of(i_detect_bad[k], i_class_bad[k], i_power_denied[k]);
		end
		for (int p = 0; p < N_CH / 2; p++) begin
			if (i_four_pair[p] && i_single_signature[p]) begin
				if (hit[2*p] || hit[2*p+1]) begin
					code[2*p]   = hit[2*p] ? code[2*p] : code[2*p+1];
					code[2*p+1] = code[2*p];
					hit[2*p]    = 1'b1;
					hit[2*p+1]  = 1'b1;
				end
			end
		end
		for (int k = 0; k < N_CH; k++) begin
			if (hit[k]) begin
				next_turn_on_fault_cause[`CAUSE_W*k +: `CAUSE_W] = code[k];
			end
			if (i_turn_off[k]) begin
				next_turn_on_fault_cause[`CAUSE_W*k +: `CAUSE_W] = `CAUSE_NONE;
			end
		end
	end

	// Remap write with its guards; a refused write gives no indication
	always_comb begin
		logic write_hit;
		logic write_ok;
		write_hit = state == pse_fault_remap_pkg::ST_WRITE && cmd_code == `CMD_PORT_REMAP;
		write_ok  = group_all_off(i_ch_off) && remap_unique(cmd_data);
		next_port_remap_control = port_remap_control;
		if (write_hit && write_ok) begin
			next_port_remap_control = cmd_data;
		end
	end

	// Remap survives the reset pin; only power-on restores identity
	always_ff @(posedge i_clk or posedge i_por) begin
		if (i_por) begin
			port_remap_control <= `REMAP_RESET;
		end else begin
			port_remap_control <= next_port_remap_control;
		end
	end

	// Remaining state clears on the reset pin
	always_ff @(posedge i_clk or posedge i_reset) begin
		if (i_reset) begin
			state               <= pse_fault_remap_pkg::ST_IDLE;
			turn_on_fault_cause <= `FAULT_RESET;
			rd_data             <= `REG_ZERO;
			rd_valid            <= 1'b0;
			cmd_code            <= `REG_ZERO;
			cmd_data            <= `REG_ZERO;
		end else begin
			state               <= next_state;
			turn_on_fault_cause <= next_turn_on_fault_cause;
			rd_data             <= next_rd_data;
			rd_valid            <= next_rd_valid;
			cmd_code            <= next_cmd_code;
			cmd_data            <= next_cmd_data;
		end
	end

	// Outputs come straight from the registers
	assign o_rd_data             = rd_data;
	assign o_rd_valid            = rd_valid;
	assign o_port_remap_control  = port_remap_control;
	assign o_turn_on_fault_cause = turn_on_fault_cause;

endmodule

/* tb/host_model.sv */
// Host model that issues register commands
module host_model (
	input  logic       i_clk,
	output logic       o_vld,
	output logic       o_wr,
	output logic [7:0] o_code,
	output logic [7:0] o_data
);
	timeunit 1ns;
	timeprecision 1ns;
	initial {o_vld, o_wr, o_code, o_data} = '0;
	// One-cycle request; stale data is inverted so it never looks valid
	task automatic cmd(input logic w, input logic [7:0] c, input logic [7:0] d);
		@(posedge i_clk);
		{o_vld, o_wr, o_code, o_data} <= {1'b1, w, c, d};
		@(posedge i_clk);
		o_vld <= 1'b0;
		o_data <= ~d;
	endtask
endmodule

/* tb/pse_fault_remap_monitor.sv */
// Checker for the fault cause and remap registers
module pse_fault_remap_monitor #(
	parameter int N_CH = 4
) (
	input  logic            i_clk,
	input  logic            i_reset,
	input  logic            i_por,
	input  logic            i_cmd_valid,
	input  logic            i_cmd_write,
	input  logic [7:0]      i_cmd_code,
	input  logic [7:0]      i_cmd_data,
	input  logic [N_CH-1:0] i_ch_off,
	input  logic [N_CH-1:0] i_turn_off,
	input  logic [N_CH-1:0] i_start_fail,
	input  logic [N_CH-1:0] i_detect_bad,
	input  logic [N_CH-1:0] i_class_bad,
	input  logic [N_CH-1:0] i_power_denied,
	input  logic [N_CH-1:0] i_power_enable_change_flag,
	input  logic [1:0]      i_four_pair,
	input  logic [1:0]      i_single_signature,
	input  logic [7:0]      o_rd_data,
	input  logic            o_rd_valid,
	input  logic [7:0]      o_port_remap_control,
	input  logic [7:0]      o_turn_on_fault_cause
);
	timeunit 1ns;
	timeprecision 1ns;
	wire logic [7:0] fc    = o_turn_on_fault_cause;
	wire logic       rm_wr = i_cmd_valid && i_cmd_write && i_cmd_code == 8'h26;
	default clocking @(posedge i_clk);
	endclocking
	default disable iff (i_reset || i_por);
	// Remap write of one byte, then the quiet cycle in which it acts
	sequence remap_wr_s(off, dat);
		rm_wr && i_ch_off == off && i_cmd_data == dat ##1 i_ch_off == off && !i_cmd_valid;
	endsequence
	// Start fault with detect bad on channel one, change flag clear and no turn-off
	sequence fault0_s;
		i_start_fail[0] && i_detect_bad[0] && !i_power_enable_change_flag[0] && !i_turn_off[0];
	endsequence
	a_off_clears: assert property (i_turn_off[0] |=> fc[1:0] == 2'h0)
		else $error("cause field of channel one not cleared by turn-off");
	a_cause_code: assert property (fault0_s |=>
		fc[1:0] == ($past(i_power_denied[0]) ? 2'h3 : $past(i_class_bad[0]) ? 2'h2 : 2'h1))
		else $error("cause code of channel one wrong");
	a_flag_blocks: assert property (i_start_fail == 4'h1 && i_power_enable_change_flag[0]
		&& i_turn_off == 4'h0 && !$past(i_cmd_valid) |=> $stable(fc[1:0]))
		else $error("cause latched although change flag set");
	a_pair_joint: assert property (i_four_pair[0] && i_single_signature[0] && i_start_fail[1:0] != 2'h0
		&& i_turn_off[1:0] == 2'h0 && i_power_enable_change_flag[1:0] == 2'h0 |=> fc[3:2] == fc[1:0])
		else $error("single signature pair codes differ");
	a_pair_apart: assert property (i_four_pair[0] && !i_single_signature[0] && i_start_fail[1:0] == 2'h1
		&& !i_turn_off[1] && !$past(i_cmd_valid) |=> $stable(fc[3:2]))
		else $error("dual signature pair partner field changed");
	a_remap_needs_off: assert property (remap_wr_s(4'h7, 8'h1B) |=> $stable(o_port_remap_control))
		else $error("remap write taken with a channel on");
	a_remap_takes: assert property (remap_wr_s(4'hF, 8'h1B) |=> o_port_remap_control == 8'h1B)
		else $error("remap write not taken");
	a_remap_dups: assert property (remap_wr_s(4'hF, 8'h00) |=> $stable(o_port_remap_control))
		else $error("remap write with duplicate codes taken");
	a_remap_survives: assert property (disable iff (i_por) i_reset && $past(i_reset)
		|=> $stable(o_port_remap_control)) else $error("remap changed during reset pin");
endmodule
bind pse_fault_remap pse_fault_remap_monitor #(.N_CH(N_CH)) pse_fault_remap_monitor_inst (.*);

/* tb/tb_top.sv */
// Testbench for the fault cause and remap registers
module tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic i_clk = 0, i_reset = 1, i_por = 1, i_cmd_valid, i_cmd_write, o_rd_valid;
	logic [7:0] i_cmd_code, i_cmd_data, o_rd_data, o_port_remap_control, o_turn_on_fault_cause, q[$];
	logic [3:0] i_ch_off = '1, i_turn_off = 0, i_start_fail = 0, i_detect_bad = '1, i_class_bad = 0, i_power_denied = 0;
	logic [3:0] i_power_enable_change_flag = 0;
	logic [1:0] i_four_pair = 0, i_single_signature = 0;
	int n_errors = 0, checked = 0, cyc = 0, k, c, f;
	pse_fault_remap pse_fault_remap_inst (.*);
	host_model host_model_inst (.i_clk, .o_vld(i_cmd_valid), .o_wr(i_cmd_write), .o_code(i_cmd_code), .o_data(i_cmd_data));
	always #2 i_clk = ~i_clk;
	// Expected answer is queued before the read goes out
	task automatic rd(input logic [7:0] a, input logic [7:0] x);
		q.push_back(x);
		host_model_inst.cmd(0, a, 8'h00);
		repeat (3) @(posedge i_clk);
	endtask
	task automatic wr(input logic [7:0] d);
		host_model_inst.cmd(1, 8'h26, d);
		repeat (2) @(posedge i_clk);
	endtask
	task automatic flt(input int ch, input int code, input int flag);
		@(posedge i_clk);
		i_start_fail <= 4'h1 << ch;
		i_class_bad <= {4{code == 2}};
		i_power_denied <= {4{code == 3}};
		i_power_enable_change_flag <= {4{flag[0]}};
		@(posedge i_clk);
		i_start_fail <= 4'h0;
	endtask
	task automatic cmp(input logic [7:0] x, input logic [7:0] y);
		checked++;
		if (x !== y) begin
			n_errors++;
			$display("mismatch rd_data exp %h got %h", x, y);
		end
	endtask
	// Each answer is matched against the oldest note
	always @(posedge i_clk) if (o_rd_valid === 1'b1) cmp(q.pop_front(), o_rd_data);
	always @(posedge i_clk) if (++cyc == 1500) begin
		n_errors++;
		tally_and_finish();
	end
	task automatic tally_and_finish;
		// An answer that never came leaves its note behind
		if (q.size() != 0) n_errors++;
		$display("checked %0d mismatches %0d", checked, n_errors);
		if (n_errors == 0 && checked > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	initial begin
		void'($urandom(4));
		repeat (20) @(posedge i_clk);
		{i_reset, i_por} <= 2'h0;
		rd(8'h26, 8'hE4);
		i_ch_off <= 4'h7;
		wr(8'h1B);
		i_ch_off <= 4'hF;
		rd(8'h26, 8'hE4);
		wr(8'h00);
		rd(8'h26, 8'hE4);
		wr(8'h1B);
		i_reset <= 1'b1;
		repeat (2) @(posedge i_clk);
		i_reset <= 1'b0;
		rd(8'h26, 8'h1B);
		$display("remap test done");
		for (int i = 0; i < 10; i++) begin
			k = $urandom % 4;
			c = 1 + $urandom % 3;
			f = $urandom % 4 == 0;
			flt(k, c, f);
			rd(8'h25, f ? 8'h00 : 8'(c << 2 * k));
		end
		flt(0, 2, 1);
		rd(8'h25, 8'h00);
		$display("cause test done");
		{i_four_pair, i_single_signature} <= 4'h5;
		flt(0, 3, 0);
		rd(8'h25, 8'h0F);
		i_single_signature <= 2'h0;
		flt(0, 3, 0);
		rd(8'h24, 8'h03);
		@(posedge i_clk) i_turn_off <= 4'h1;
		@(posedge i_clk) i_turn_off <= 4'h0;
		rd(8'h24, 8'h00);
		$display("pair test done");
		tally_and_finish();
	end
endmodule
